// File: hw/csfe_capture.v
`timescale 1ns/10ps
`include "csfe_map.vh"

// Operation
// - Three selectable timing modes offered.
// - Embedded mode uses only pixel clock.
// - Blanking between end and start dropped.
// - Codes stripped, frame/line syncs regenerated.
// - Frame sync active edge starts frame.
// - Gated mode counts edges only while valid.
// - Data sampled on valid pixel clock edge.
// - Capture stops after line valid drops.
// - Free-running mode ignores line valid.
// - Free-running mode takes every clock edge while frame sync is active.
// - Sync and clock polarities selectable.
// - Invert bit moves sampling to falling edge.
module csfe_capture #(
    parameter DATA_W = 8
) (
    // System clock, reset and enable.
    input  wire              i_clk,
    input  wire              i_reset,
    input  wire              i_ce,
    // Register port.
    input  wire [3:0]        i_addr,
    input  wire [31:0]       i_wdata,
    input  wire              i_wr,
    input  wire              i_rd,
    output reg  [31:0]       o_rdata,
    // Sensor pins.
    input  wire              i_sensor_pixel_clock,
    input  wire              i_frame_sync_in,
    input  wire              i_line_valid_in,
    input  wire [DATA_W-1:0] i_pix_data,
    // Captured pixel stream.
    output reg               o_pix_valid,
    output reg  [DATA_W-1:0] o_pix_data,
    output reg               o_frame_start,
    output reg               o_frame_sync,
    output reg               o_line_sync
);

    // Embedded decoder states: idle or within a code preamble.
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_FF   = 2'h1;
    localparam [1:0] ST_Z1   = 2'h2;
    localparam [1:0] ST_Z2   = 2'h3;

    // Register written by software.
    reg  [`CSFE_CFG_W-1:0] cfg_r;
    // Configuration actually in force.
    reg  [`CSFE_CFG_W-1:0] act_r;
    // Frame counter shown in status.
    reg  [15:0]            frames_r;

    // Two-stage synchronisers for the sensor pins.
    reg  [1:0]             pck_s_r;
    reg  [1:0]             fs_s_r;
    reg  [1:0]             lv_s_r;
    reg  [DATA_W-1:0]      dat_a_r;
    reg  [DATA_W-1:0]      dat_b_r;
    // Previous synchronised levels for edge finding.
    reg                    pck_d_r;
    reg                    fs_d_r;

    // Embedded decoder state.
    reg  [1:0]             st_r;
    reg  [1:0]             st_nxt;
    reg                    emb_act_r;
    reg                    emb_vb_r;

    // Decoded fields of the active configuration.
    wire [1:0]             mode;
    wire                   enable;
    wire                   fs_level;
    wire                   lv_level;
    wire                   fs_prev;
    wire                   pck_edge;
    wire                   fs_edge;
    wire                   frame_idle;

    // Level of a pin after polarity correction.
    function polar;
        input lvl;
        input inv;
        begin
            polar = lvl ^ inv;
        end
    endfunction

    assign mode   = act_r[`CSFE_CFG_MODE_HI:`CSFE_CFG_MODE_LO];
    assign enable = act_r[`CSFE_CFG_ENABLE];

    // Frame sync corrected so the active edge is a rise.
    assign fs_level = polar(fs_s_r[1], act_r[`CSFE_CFG_FS_FALL]);
    assign fs_prev  = polar(fs_d_r, act_r[`CSFE_CFG_FS_FALL]);
    // Line valid corrected so the active level is high.
    assign lv_level = polar(lv_s_r[1], act_r[`CSFE_CFG_LV_LOW]);

    // The invert bit selects the falling edge of the pixel clock.
    assign pck_edge = act_r[`CSFE_CFG_PCK_INV] ?
                      (pck_d_r & ~pck_s_r[1]) :
                      (~pck_d_r & pck_s_r[1]);

    // A rise of the corrected frame sync opens a frame.
    assign fs_edge = fs_level & ~fs_prev;

    // Between frames: sync inactive, or vertical blanking when embedded.
    assign frame_idle = (mode == `CSFE_MODE_EMBED) ?
                        emb_vb_r : ~fs_level;

    // Synchronise every sensor pin before any logic reads it.
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            pck_s_r <= 2'h0;
            fs_s_r  <= 2'h0;
            lv_s_r  <= 2'h0;
            dat_a_r <= {DATA_W{1'b0}};
            dat_b_r <= {DATA_W{1'b0}};
            pck_d_r <= 1'b0;
            fs_d_r  <= 1'b0;
        end else if (i_ce) begin
            pck_s_r <= {pck_s_r[0], i_sensor_pixel_clock};
            fs_s_r  <= {fs_s_r[0], i_frame_sync_in};
            lv_s_r  <= {lv_s_r[0], i_line_valid_in};
            dat_a_r <= i_pix_data;
            dat_b_r <= dat_a_r;
            pck_d_r <= pck_s_r[1];
            fs_d_r  <= fs_s_r[1];
        end
    end

    // Software writes the configuration register.
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            cfg_r <= `CSFE_CFG_RESET;
        end else if (i_ce && i_wr && i_addr == `CSFE_CFG_ADDR) begin
            cfg_r <= i_wdata[`CSFE_CFG_W-1:0];
        end
    end

    // The new setting is taken over only while no frame is running.
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            act_r <= `CSFE_CFG_RESET;
        end else if (i_ce && frame_idle) begin
            act_r <= cfg_r;
        end
    end

    // Read data stands in the cycle after the read strobe.
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_rdata <= 32'h0;
        end else if (i_ce) begin
            if (i_rd) begin
                case (i_addr)
                    `CSFE_CFG_ADDR: begin
                        o_rdata <= {{(32-`CSFE_CFG_W){1'b0}}, cfg_r};
                    end
                    `CSFE_STAT_ADDR: begin
                        // Count, active mode, line and frame state.
                        o_rdata <= {frames_r, 10'h0, mode,
                                    2'h0, o_line_sync, o_frame_sync};
                    end
                    default: begin
                        // Unmapped addresses read as zero.
                        o_rdata <= 32'h0;
                    end
                endcase
            end else begin
                o_rdata <= 32'h0;
            end
        end
    end

    // Next state of the embedded code detector.
    always @* begin
        st_nxt = ST_IDLE;
        case (st_r)
            ST_IDLE: begin
                if (dat_b_r == `CSFE_CODE_FF) begin
                    st_nxt = ST_FF;
                end
            end
            ST_FF: begin
                if (dat_b_r == `CSFE_CODE_00) begin
                    st_nxt = ST_Z1;
                end
            end
            ST_Z1: begin
                if (dat_b_r == `CSFE_CODE_00) begin
                    st_nxt = ST_Z2;
                end
            end
            ST_Z2: begin
                // This word is the code itself; decode resumes after it.
                st_nxt = ST_IDLE;
            end
            default: begin
                st_nxt = ST_IDLE;
            end
        endcase
    end

    // Embedded mode: watch the data words on each valid clock edge.
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            st_r      <= ST_IDLE;
            emb_act_r <= 1'b0;
            emb_vb_r  <= 1'b1;
        end else if (i_ce) begin
            if (!enable || mode != `CSFE_MODE_EMBED) begin
                st_r      <= ST_IDLE;
                emb_act_r <= 1'b0;
                emb_vb_r  <= 1'b1;
            end else if (pck_edge) begin
                st_r <= st_nxt;
                if (st_r == ST_Z2) begin
                    // Start code opens a line, end code closes it.
                    emb_act_r <= ~dat_b_r[`CSFE_XY_H_BIT];
                    emb_vb_r  <= dat_b_r[`CSFE_XY_V_BIT];
                end else if (dat_b_r == `CSFE_CODE_FF) begin
                    // A preamble ends the active run at once.
                    emb_act_r <= 1'b0;
                end
            end
        end
    end

    // Pixel capture, sync regeneration and frame counting.
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_pix_valid   <= 1'b0;
            o_pix_data    <= {DATA_W{1'b0}};
            o_frame_start <= 1'b0;
            o_frame_sync  <= 1'b0;
            o_line_sync   <= 1'b0;
            frames_r      <= 16'h0;
        end else if (i_ce) begin
            o_pix_valid   <= 1'b0;
            o_frame_start <= 1'b0;
            if (!enable) begin
                // Capture switched off: syncs fall, nothing passes.
                o_frame_sync <= 1'b0;
                o_line_sync  <= 1'b0;
            end else begin
                case (mode)
                    `CSFE_MODE_EMBED: begin
                        // Syncs come from decoded codes, not pins.
                        o_frame_sync <= ~emb_vb_r;
                        o_line_sync  <= emb_act_r;
                        if (emb_vb_r && pck_edge && st_r == ST_Z2 &&
                            !dat_b_r[`CSFE_XY_V_BIT]) begin
                            o_frame_start <= 1'b1;
                            frames_r      <= frames_r + 16'h1;
                        end
                        // Only words inside a line that are no code.
                        if (pck_edge && emb_act_r && st_r == ST_IDLE &&
                            dat_b_r != `CSFE_CODE_FF) begin
                            o_pix_valid <= 1'b1;
                            o_pix_data  <= dat_b_r;
                        end
                    end
                    `CSFE_MODE_GATED: begin
                        o_frame_sync <= fs_level;
                        o_line_sync  <= lv_level;
                        if (fs_edge) begin
                            o_frame_start <= 1'b1;
                            frames_r      <= frames_r + 16'h1;
                        end
                        // Edges count only while line valid is active.
                        if (pck_edge && lv_level && fs_level) begin
                            o_pix_valid <= 1'b1;
                            o_pix_data  <= dat_b_r;
                        end
                    end
                    `CSFE_MODE_FREE: begin
                        // Line valid pin plays no part here.
                        o_frame_sync <= fs_level;
                        o_line_sync  <= fs_level;
                        if (fs_edge) begin
                            o_frame_start <= 1'b1;
                            frames_r      <= frames_r + 16'h1;
                        end
                        // Clock only runs for real data, so take all while frame sync is active.
                        if (pck_edge && fs_level) begin
                            o_pix_valid <= 1'b1;
                            o_pix_data  <= dat_b_r;
                        end
                    end
                    default: begin
                        // Reserved mode code captures nothing.
                        o_frame_sync <= 1'b0;
                        o_line_sync  <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule

// File: hw/csfe_map.vh
`ifndef CSFE_MAP_VH
`define CSFE_MAP_VH

// Register word offsets.
`define CSFE_CFG_ADDR     4'h0
`define CSFE_STAT_ADDR    4'h4

// Configuration field positions.
`define CSFE_CFG_MODE_LO  0
`define CSFE_CFG_MODE_HI  1
`define CSFE_CFG_FS_FALL  2
`define CSFE_CFG_LV_LOW   3
`define CSFE_CFG_PCK_INV  4
`define CSFE_CFG_ENABLE   5
`define CSFE_CFG_W        6
`define CSFE_CFG_RESET    6'h01

// Timing mode codes.
`define CSFE_MODE_EMBED   2'h0
`define CSFE_MODE_GATED   2'h1
`define CSFE_MODE_FREE    2'h2

// Embedded timing code words.
`define CSFE_CODE_FF      8'hFF
`define CSFE_CODE_00      8'h00
`define CSFE_XY_V_BIT     5
`define CSFE_XY_H_BIT     4

`endif

// File: test/csfe_sensor_model.sv
`timescale 1ns/10ps
// Behavioural image sensor driving the pixel bus at a 125 ns pixel period.
module csfe_sensor_model (
    // Sensor pins.
    output logic       o_pclk,
    output logic       o_fsync,
    output logic       o_lvalid,
    output logic [7:0] o_data
);
    logic fs_low = 1'b0; // Frame sync is active low when set.
    logic lv_low = 1'b0; // Line valid is active low when set.
    // The pixel clock idles low outside transfers.
    initial begin
        o_pclk   = 1'b0;
        o_fsync  = 1'b0;
        o_lvalid = 1'b0;
        o_data   = 8'h5A;
    end
    // One word, stable across both clock edges, then the bus is driven to its inverse.
    task automatic word(input logic [7:0] d);
        o_data = d;
        #31 o_pclk = 1'b1;
        #62 o_pclk = 1'b0;
        #16 o_data = ~d;
        #16;
    endtask
    // Frame sync to its active or inactive level.
    task automatic frame(input logic act);
        o_fsync = act ^ fs_low;
        #250;
    endtask
    // A line of n counting words, held inside line valid.
    task automatic line(input int n, input logic [7:0] b);
        o_lvalid = ~lv_low;
        #40;
        for (int i = 0; i < n; i++) begin
            word(b + 8'(i));
        end
        o_lvalid = lv_low;
        #40;
    endtask
endmodule

// File: test/csfe_capture_asserts.sv
`timescale 1ns/10ps
// Port-level checks of the capture front end.
module csfe_capture_asserts #(
    parameter DATA_W = 8
) (
    input wire              i_clk,
    input wire              i_reset,
    input wire              i_ce,
    input wire [3:0]        i_addr,
    input wire [31:0]       i_wdata,
    input wire              i_wr,
    input wire              i_rd,
    input wire [31:0]       o_rdata,
    input wire              i_sensor_pixel_clock,
    input wire              i_frame_sync_in,
    input wire              i_line_valid_in,
    input wire [DATA_W-1:0] i_pix_data,
    input wire              o_pix_valid,
    input wire [DATA_W-1:0] o_pix_data,
    input wire              o_frame_start,
    input wire              o_frame_sync,
    input wire              o_line_sync
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    logic [5:0] cfg_r;    // Shadow of the configuration register.
    logic       rd_cfg_r; // A configuration read was taken last cycle.
    // Track writes and reads of the configuration register.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            cfg_r    <= 6'h01;
            rd_cfg_r <= 1'b0;
        end else begin
            rd_cfg_r <= i_ce && i_rd && i_addr == 4'h0;
            if (i_ce && i_wr && i_addr == 4'h0) begin
                cfg_r <= i_wdata[5:0];
            end
        end
    end
    // A pixel pulse clears after one cycle.
    sequence s_pix_clear;
        ##1 !o_pix_valid;
    endsequence
    // The pixel clock pin moved two to eight cycles earlier.
    sequence s_pin_edge;
        $past(i_sensor_pixel_clock, 2) != $past(i_sensor_pixel_clock, 8);
    endsequence
    AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
        else $error("read data not zero outside a read answer");
    AST_CFG_READ: assert property (rd_cfg_r |-> o_rdata[5:0] == cfg_r)
        else $error("configuration read back differs");
    AST_PV_PULSE: assert property (o_pix_valid |-> s_pix_clear)
        else $error("pixel pulse longer than one cycle");
    AST_PV_CAUSE: assert property (o_pix_valid |-> s_pin_edge)
        else $error("pixel without a pixel clock edge");
    AST_DATA_HOLD: assert property (!o_pix_valid |-> $stable(o_pix_data))
        else $error("pixel data changed without a capture");
    AST_PV_IN_LINE: assert property (o_pix_valid |-> o_frame_sync && o_line_sync)
        else $error("pixel outside an active line");
    AST_FS_PULSE: assert property (o_frame_start |=> !o_frame_start)
        else $error("frame start longer than one cycle");
    AST_FS_RISE: assert property (o_frame_start |-> !$past(o_frame_sync) ##1 o_frame_sync)
        else $error("frame start not at frame sync rise");
endmodule

// File: test/tb.sv
`timescale 1ns/10ps
`include "csfe_map.vh"
// Self-checking bench of the capture front end.
module tb;
    logic        i_clk = 1'b0;
    logic        i_reset = 1'b1;
    logic [3:0]  i_addr = 4'h0;
    logic [31:0] i_wdata = 32'h0;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic        i_ce = 1'b1; // Clock enable, dropped once to check the freeze.
    wire  [31:0] rdata;
    wire         pclk, fsync, lval, pv, fst, fsy, lsy;
    wire  [7:0]  sdat, pdat;
    int          num_errors = 0;
    int          checks = 0;
    int          frames = 0; // Frame start pulses seen.
    logic [7:0]  got[$];     // Captured pixels.
    // A row: configuration, pixel count and fourth pixel expected.
    typedef struct { logic [5:0] cfg; int npix; logic [7:0] p3; } csfe_row_t;
    csfe_row_t rows[6] = '{'{6'h21, 6, 8'h20}, '{6'h35, 6, 8'h20}, '{6'h22, 7, 8'hA5},
                           '{6'h23, 0, 8'h00}, '{6'h01, 0, 8'h00}, '{6'h2D, 6, 8'h20}};
    // Embedded stream: blanking, two active lines, filler between them.
    logic [7:0]  emb[27] = '{8'hFF, 8'h00, 8'h00, 8'hB0, 8'hFF, 8'h00, 8'h00, 8'h80,
                             8'h10, 8'h11, 8'h12, 8'hFF, 8'h00, 8'h00, 8'h90, 8'h10,
                             8'h10, 8'hFF, 8'h00, 8'h00, 8'h80, 8'h20, 8'h21, 8'hFF,
                             8'h00, 8'h00, 8'h90};
    initial begin
        forever #2 i_clk = ~i_clk;
    end
    csfe_capture uut (.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata),
        .i_sensor_pixel_clock(pclk), .i_frame_sync_in(fsync), .i_line_valid_in(lval),
        .i_pix_data(sdat), .o_pix_valid(pv), .o_pix_data(pdat), .o_frame_start(fst),
        .o_frame_sync(fsy), .o_line_sync(lsy));
    csfe_sensor_model u_sen (.o_pclk(pclk), .o_fsync(fsync), .o_lvalid(lval), .o_data(sdat));
    // Collect pixels and frame starts.
    always @(posedge i_clk) begin
        if (pv === 1'b1) got.push_back(pdat);
        if (fst === 1'b1) frames++;
    end
    task automatic chk(input logic [31:0] a, input logic [31:0] e, input string m);
        checks++;
        if (a !== e) begin
            num_errors++;
            $display("[ERR] %0t %s got %h want %h", $time, m, a, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe.
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] k,
                      input string m);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 chk(rdata & k, e, m);
    endtask
    task automatic test_done();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge i_clk);
        i_reset <= 1'b0;
        rd(`CSFE_CFG_ADDR, 32'h01, 32'h3F, "cfg reset");
        foreach (rows[i]) begin
            wr(`CSFE_CFG_ADDR, {26'h0, rows[i].cfg});
            rd(`CSFE_CFG_ADDR, {26'h0, rows[i].cfg}, 32'h3F, "cfg readback");
            u_sen.fs_low = rows[i].cfg[2];
            u_sen.lv_low = rows[i].cfg[3];
            // A new frame sync polarity is taken at once; park the pin inactive for it.
            u_sen.frame(1'b0);
            #500 got.delete();
            frames = 0;
            u_sen.frame(1'b1);
            u_sen.line(3, 8'h10);
            u_sen.word(8'hA5);
            u_sen.line(3, 8'h20);
            u_sen.frame(1'b0);
            #200 chk(got.size(), rows[i].npix, "pixel count");
            chk(frames, rows[i].npix != 0, "frame starts");
            if (rows[i].npix > 0) chk(got[3], rows[i].p3, "fourth pixel");
            rd(`CSFE_STAT_ADDR, {26'h0, rows[i].cfg[1:0], 4'h0}, 32'h33, "status");
        end
        wr(4'h8, 32'h3F);
        rd(4'h8, 32'h0, 32'hFFFFFFFF, "unmapped read");
        wr(`CSFE_CFG_ADDR, 32'h21);
        u_sen.fs_low = 1'b0;
        u_sen.lv_low = 1'b0;
        u_sen.frame(1'b0);
        #500 got.delete();
        u_sen.frame(1'b1);
        // With the enable low, neither a write nor a whole line may leave a trace.
        @(posedge i_clk);
        i_ce <= 1'b0;
        wr(`CSFE_CFG_ADDR, 32'h22);
        u_sen.line(2, 8'h50);
        @(posedge i_clk);
        i_ce <= 1'b1;
        rd(`CSFE_CFG_ADDR, 32'h21, 32'h3F, "write while frozen");
        chk(got.size(), 0, "line while frozen");
        wr(`CSFE_CFG_ADDR, 32'h23);
        u_sen.line(2, 8'h30);
        u_sen.frame(1'b0);
        u_sen.frame(1'b1);
        u_sen.line(2, 8'h40);
        u_sen.frame(1'b0);
        chk(got.size(), 2, "deferred mode change");
        wr(`CSFE_CFG_ADDR, 32'h20);
        #500 got.delete();
        frames = 0;
        foreach (emb[i]) u_sen.word(emb[i]);
        #200 chk(got.size(), 5, "embedded count");
        chk({got[0], got[2], got[4]}, 24'h101221, "embedded data");
        chk(frames, 1, "embedded frame");
        @(posedge i_clk);
        i_reset <= 1'b1;
        repeat (2) @(posedge i_clk);
        #1 chk({pv, fst, fsy, lsy}, 4'h0, "outputs in reset");
        @(posedge i_clk);
        i_reset <= 1'b0;
        rd(`CSFE_CFG_ADDR, 32'h01, 32'h3F, "cfg after reset");
        test_done();
    end
    // Cut a hang short.
    initial begin
        #200000;
        num_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        test_done();
    end
endmodule
bind csfe_capture csfe_capture_asserts #(.DATA_W(DATA_W)) u_chk (.i_clk, .i_reset, .i_ce,
    .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_sensor_pixel_clock, .i_frame_sync_in,
    .i_line_valid_in, .i_pix_data, .o_pix_valid, .o_pix_data, .o_frame_start,
    .o_frame_sync, .o_line_sync);
